// ### rtl/sfp_pkg.sv
/*
 * Shared constants for the serial flash pin interface: byte framing,
 * reset values, link states and the write-protect region table.
 * Assumes nothing of its surroundings; every user names package::item.
 */
package sfp_pkg;

	// Byte framing on the serial link
	localparam int unsigned BYTE_BITS = 8;
	localparam int unsigned CNT_W = 3;
	localparam logic [2:0] CNT_LAST = 3'h7;
	localparam logic [2:0] CNT_RST = 3'h0;

	// Synchroniser depth for pin inputs
	localparam int unsigned SYNC_STAGES = 2;

	// Number of synchronised pins and their slots
	localparam int unsigned PIN_W = 5;

	// Flash array address width and protect field width
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned BP_W = 3;

	// Reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic PIN_HIGH_RST = 1'b1;

	// Lowest protected address for each protect code; all-ones means none
	localparam logic [19:0] PROT_NONE = 20'hfffff;
	localparam logic [19:0] PROT_BP1 = 20'hf0000;
	localparam logic [19:0] PROT_BP2 = 20'he0000;
	localparam logic [19:0] PROT_BP3 = 20'hc0000;
	localparam logic [19:0] PROT_BP4 = 20'h80000;
	localparam logic [19:0] PROT_ALL = 20'h00000;

	// Link states, Gray along deselected -> selected -> paused
	typedef enum logic [1:0] {
		ST_UNARMED = 2'h0,
		ST_DESEL = 2'h1,
		ST_SEL = 2'h3,
		ST_PAUSE = 2'h2
	} sfp_state_t;

endpackage

// ### rtl/sfp_pins_if.sv
/*
 * Carries the synchronised pin levels from the synchroniser to the
 * link logic. Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface sfp_pins_if;
	logic cs_b; // Chip select, active low
	logic sck; // Serial clock level
	logic si; // Serial data in
	logic hold_b; // Pause, active low
	logic wp_b; // Write protect, active low

	modport src (output cs_b, sck, si, hold_b, wp_b);
	modport dst (input cs_b, sck, si, hold_b, wp_b);
endinterface

// ### rtl/sfp_sync.sv
/*
 * Two-stage synchroniser for the five serial pins, delivered through
 * the pin interface. Assumes raw pins are asynchronous to clock_i.
 */
`timescale 1ns/1ps
module sfp_sync (
	input wire logic clock_i, // System clock
	input wire logic rst_b_i, // Synchronous reset, active low
	input wire logic [sfp_pkg::PIN_W-1:0] pins_i, // {cs_b,sck,si,hold_b,wp_b}
	sfp_pins_if.src pins // Synchronised levels
);
	logic [sfp_pkg::PIN_W-1:0] meta_q, meta_d; // First stage, read only by stage two
	logic [sfp_pkg::PIN_W-1:0] sync_q, sync_d; // Second stage
	// Reset levels: select and clock low, matching the edge detectors' reset,
	// so a select already low at reset gives no false fall; pause and protect high
	localparam logic [sfp_pkg::PIN_W-1:0] IDLE = 5'h03;

	// Next values: plain shift through the two stages
	always_comb begin
		meta_d = pins_i;
		sync_d = meta_q;
	end

	// Registers only
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			meta_q <= IDLE;
			sync_q <= IDLE;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign pins.cs_b = sync_q[4];
	assign pins.sck = sync_q[3];
	assign pins.si = sync_q[2];
	assign pins.hold_b = sync_q[1];
	assign pins.wp_b = sync_q[0];
endmodule

// ### rtl/sfp_link.sv
/*
 * Serial flash pin interface, device side: chip select, serial clock
 * edges, byte shifting, pause and write-protect gating.
 * Assumes a 50 MHz clock_i well above the serial clock rate, and an
 * array core that supplies bytes, busy state and protect bits.
 */
// What this block does
// - Output bits change after serial clock falls
// - Input bits captured on serial clock rise
// - Select low means active and accepting
// - Select high floats the serial output
// - No command before first select fall
// - Standby when deselected and nothing busy
// - Pause suspends exchange, keeps device selected
// - Paused: output floats, clock and input ignored
// - Write protect blocks writes to protected region
// - Mode 0 or 3, rise samples
// - Whole eight-bit bytes, one bit per clock
`timescale 1ns/1ps
module sfp_link #(
	parameter int unsigned ADDR_W = sfp_pkg::ADDR_W // Array address width
) (
	input wire logic clock_i, // System clock
	input wire logic rst_b_i, // Synchronous reset, active low
	input wire logic cs_b_i, // Chip select pin, active low
	input wire logic sck_i, // Serial clock pin
	input wire logic si_i, // Serial data in pin
	input wire logic hold_b_i, // Pause pin, active low
	input wire logic wp_b_i, // Write-protect pin, active low
	output logic so_o, // Serial data out
	output logic so_oe_o, // Serial out enable, high drives
	input wire logic [7:0] tx_byte_i, // Next byte to send
	output logic tx_req_o, // Pulse: tx_byte_i taken next fall
	output logic [7:0] rx_byte_o, // Last received byte
	output logic rx_valid_o, // Pulse: rx_byte_o fresh
	output logic frame_start_o, // Pulse: select fell, armed
	output logic active_o, // Selected, accepting or paused
	output logic paused_o, // Exchange suspended
	input wire logic busy_i, // Program/erase/status write running
	output logic standby_o, // Deselected and idle
	input wire logic [sfp_pkg::BP_W-1:0] block_protect_bits_i, // Protect code
	input wire logic prog_req_i, // Pulse: array write check request
	input wire logic [ADDR_W-1:0] prog_addr_i, // Address to write
	output logic prog_ack_o, // Pulse: check result ready
	output logic prog_ok_o // Write allowed
);
	sfp_pins_if pins(); // Synchronised pin levels

	sfp_sync u_sync (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.pins_i({cs_b_i, sck_i, si_i, hold_b_i, wp_b_i}),
		.pins(pins)
	);

	sfp_pkg::sfp_state_t state_q, state_d; // Link state
	logic cs_prev_q, cs_prev_d; // Select level last cycle
	logic sck_prev_q, sck_prev_d; // Serial clock level last cycle
	logic [2:0] bit_cnt_q, bit_cnt_d; // Bits of current byte
	logic [7:0] rx_sh_q, rx_sh_d; // Receive shifter
	logic [7:0] tx_sh_q, tx_sh_d; // Transmit shifter
	logic [7:0] rx_byte_q, rx_byte_d; // Held received byte
	logic rx_valid_q, rx_valid_d; // Byte done pulse
	logic tx_req_q, tx_req_d; // Next byte request pulse
	logic start_q, start_d; // Frame start pulse
	logic active_q, active_d; // Registered active flag
	logic standby_q, standby_d; // Registered standby flag
	logic ack_q, ack_d; // Protect check acknowledge
	logic ok_q, ok_d; // Protect check result
	logic cs_fall; // Select fell this cycle
	logic sck_rise; // Serial clock rose this cycle
	logic sck_fall; // Serial clock fell this cycle
	logic shifting; // Edges honoured
	logic [ADDR_W-1:0] prot_base; // Lowest protected address
	logic in_region; // Request address protected

	// Edge detection on synchronised levels only
	always_comb begin
		cs_prev_d = pins.cs_b;
		sck_prev_d = pins.sck;
		// Reset value of cs_prev is low, so a select already low at reset is no edge
		cs_fall = cs_prev_q && !pins.cs_b;
		sck_rise = !sck_prev_q && pins.sck;
		sck_fall = sck_prev_q && !pins.sck;
	end

	// Link state: select, arming after reset, pause
	always_comb begin
		state_d = state_q;
		start_d = 1'b0;
		case (state_q)
			sfp_pkg::ST_UNARMED, sfp_pkg::ST_DESEL: begin
				if (cs_fall) begin
					// Pause already low at select goes straight to paused
					state_d = pins.hold_b ? sfp_pkg::ST_SEL : sfp_pkg::ST_PAUSE;
					start_d = 1'b1;
				end
			end
			sfp_pkg::ST_SEL: begin
				if (pins.cs_b) begin
					state_d = sfp_pkg::ST_DESEL;
				end else if (!pins.hold_b) begin
					state_d = sfp_pkg::ST_PAUSE;
				end
			end
			sfp_pkg::ST_PAUSE: begin
				// Pause only counts while selected; select rising ends it
				if (pins.cs_b) begin
					state_d = sfp_pkg::ST_DESEL;
				end else if (pins.hold_b) begin
					state_d = sfp_pkg::ST_SEL;
				end
			end
			default: begin
				state_d = sfp_pkg::ST_UNARMED;
			end
		endcase
		active_d = (state_d == sfp_pkg::ST_SEL) || (state_d == sfp_pkg::ST_PAUSE);
		standby_d = !active_d && !busy_i;
	end

	// Byte shifting: capture on rise, launch on fall, MSB first
	always_comb begin
		shifting = (state_q == sfp_pkg::ST_SEL) && !pins.cs_b && pins.hold_b;
		bit_cnt_d = bit_cnt_q;
		rx_sh_d = rx_sh_q;
		tx_sh_d = tx_sh_q;
		rx_byte_d = rx_byte_q;
		rx_valid_d = 1'b0;
		tx_req_d = 1'b0;
		if (cs_fall && (state_q != sfp_pkg::ST_SEL)) begin
			// New frame: counter restarts, first bit ready before first rise
			bit_cnt_d = sfp_pkg::CNT_RST;
			tx_sh_d = tx_byte_i;
		end else if (shifting && sck_rise) begin
			rx_sh_d = {rx_sh_q[6:0], pins.si};
			bit_cnt_d = bit_cnt_q + 3'h1;
			if (bit_cnt_q == sfp_pkg::CNT_LAST) begin
				rx_byte_d = {rx_sh_q[6:0], pins.si};
				rx_valid_d = 1'b1;
				tx_req_d = 1'b1;
			end
		end else if (shifting && sck_fall) begin
			// At a byte boundary the next byte loads; mode 3 first fall reloads
			if (bit_cnt_q == sfp_pkg::CNT_RST) begin
				tx_sh_d = tx_byte_i;
			end else begin
				tx_sh_d = {tx_sh_q[6:0], 1'b0};
			end
		end
	end

	// Protected region lookup from the protect code
	always_comb begin
		case (block_protect_bits_i)
			3'h0: prot_base = ADDR_W'(sfp_pkg::PROT_NONE);
			3'h1: prot_base = ADDR_W'(sfp_pkg::PROT_BP1);
			3'h2: prot_base = ADDR_W'(sfp_pkg::PROT_BP2);
			3'h3: prot_base = ADDR_W'(sfp_pkg::PROT_BP3);
			3'h4: prot_base = ADDR_W'(sfp_pkg::PROT_BP4);
			default: prot_base = ADDR_W'(sfp_pkg::PROT_ALL);
		endcase
		// Code zero protects nothing, including the top address
		in_region = (block_protect_bits_i != 3'h0) && (prog_addr_i >= prot_base);
		ack_d = prog_req_i;
		ok_d = prog_req_i && !(!pins.wp_b && in_region);
	end

	// All state registers
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			state_q <= sfp_pkg::ST_UNARMED;
			cs_prev_q <= 1'b0;
			sck_prev_q <= 1'b0;
			bit_cnt_q <= sfp_pkg::CNT_RST;
			rx_sh_q <= sfp_pkg::BYTE_RST;
			tx_sh_q <= sfp_pkg::BYTE_RST;
			rx_byte_q <= sfp_pkg::BYTE_RST;
			rx_valid_q <= 1'b0;
			tx_req_q <= 1'b0;
			start_q <= 1'b0;
			active_q <= 1'b0;
			standby_q <= 1'b0;
			ack_q <= 1'b0;
			ok_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cs_prev_q <= cs_prev_d;
			sck_prev_q <= sck_prev_d;
			bit_cnt_q <= bit_cnt_d;
			rx_sh_q <= rx_sh_d;
			tx_sh_q <= tx_sh_d;
			rx_byte_q <= rx_byte_d;
			rx_valid_q <= rx_valid_d;
			tx_req_q <= tx_req_d;
			start_q <= start_d;
			active_q <= active_d;
			standby_q <= standby_d;
			ack_q <= ack_d;
			ok_q <= ok_d;
		end
	end

	assign so_o = tx_sh_q[7];
	// Drive only while selected and not paused; floats otherwise
	assign so_oe_o = (state_q == sfp_pkg::ST_SEL);
	assign rx_byte_o = rx_byte_q;
	assign rx_valid_o = rx_valid_q;
	assign tx_req_o = tx_req_q;
	assign frame_start_o = start_q;
	assign active_o = active_q;
	assign paused_o = (state_q == sfp_pkg::ST_PAUSE);
	assign standby_o = standby_q;
	assign prog_ack_o = ack_q;
	assign prog_ok_o = ok_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_desel_idle;
		pins.cs_b ##1 pins.cs_b && !busy_i;
	endsequence

	sequence s_protected_req;
		prog_req_i && !pins.wp_b && in_region;
	endsequence

	a_so_desel_float: assert property (pins.cs_b |=> !so_oe_o)
		else $error("serial out driven while deselected");
	a_pause_so_float: assert property (!pins.hold_b |=> !so_oe_o)
		else $error("serial out driven while paused");
	a_unarmed_no_rx: assert property (state_q == sfp_pkg::ST_UNARMED |=> !rx_valid_o)
		else $error("byte accepted before first select fall");
	a_rx_after_rise: assert property (rx_valid_o |-> $past(sck_rise))
		else $error("byte completed without a serial clock rise");
	a_tx_after_fall: assert property ($changed(so_o) && $past(state_q) == sfp_pkg::ST_SEL
		&& !$past(cs_fall) |-> $past(sck_fall))
		else $error("serial out changed without a falling edge");
	a_pause_freeze: assert property (state_q == sfp_pkg::ST_PAUSE ##1
		state_q == sfp_pkg::ST_PAUSE |-> $stable(bit_cnt_q) && $stable(rx_sh_q))
		else $error("exchange moved while paused");
	a_cnt_restart: assert property (cs_fall && state_q != sfp_pkg::ST_SEL |=> bit_cnt_q == 3'h0)
		else $error("bit counter not restarted on select fall");
	a_wp_blocks: assert property (s_protected_req |=> prog_ack_o && !prog_ok_o)
		else $error("protected write allowed");
	a_standby_entry: assert property (s_desel_idle ##1 pins.cs_b && !busy_i
		|-> ##[1:3] standby_o)
		else $error("no standby after deselect");
	a_sel_active: assert property (state_q == sfp_pkg::ST_SEL && !pins.cs_b |=> active_o)
		else $error("selected but not active");
	a_byte_boundary: assert property (rx_valid_o |-> bit_cnt_q == 3'h0)
		else $error("byte not eight bits");
endmodule

// ### tb/sfp_master.sv
/*
 * Bus master model for the flash pins: select, serial clock, data, pause.
 * Assumes the bench clock paces it; each serial clock period is eight clocks, three low and five high.
 */
`timescale 1ns/1ps
module sfp_master (
	input wire logic clock_i, // Bench clock
	input wire logic so_i, // Device data out
	input wire logic so_oe_i, // Device drive enable
	output logic cs_b_o, // Select, active low
	output logic sck_o, // Serial clock
	output logic si_o, // Data to device
	output logic hold_b_o // Pause, active low
);
	logic m3_q = 1'b0; // Mode 3 when high
	logic flt_q = 1'b0; // Pattern on a released line
	// Released line toggles so a stale bit never passes for data
	wire so_w = so_oe_i ? so_i : flt_q;
	always @(posedge clock_i) flt_q <= ~flt_q;
	// Select held low through reset: not an arming edge
	initial begin
		cs_b_o = 1'b0;
		sck_o = 1'b0;
		si_o = 1'b0;
		hold_b_o = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// Idle level first, then the arming select fall
	task automatic sel(input logic m3);
		m3_q = m3;
		@(posedge clock_i);
		sck_o <= m3;
		wt(4);
		cs_b_o <= 1'b0;
		wt(8);
	endtask
	task automatic desel();
		@(posedge clock_i);
		cs_b_o <= 1'b1;
		wt(8);
	endtask
	// Shift n bits MSB first; pause with junk edges before bit hat
	task automatic bits(input logic [7:0] tx, input int n, input int hat,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			@(posedge clock_i);
			sck_o <= 1'b0;
			si_o <= tx[i];
			wt(3);
			if (i == hat) begin
				hold_b_o <= 1'b0;
				repeat (4) begin
					wt(4);
					sck_o <= ~sck_o;
					si_o <= ~si_o;
				end
				wt(4);
				si_o <= tx[i];
				hold_b_o <= 1'b1;
				wt(4);
			end
			sck_o <= 1'b1;
			wt(4);
			// Sampled late in the high half, well clear of the change
			rx[i] = so_w;
		end
		if (!m3_q) begin
			@(posedge clock_i);
			sck_o <= 1'b0;
		end
	endtask
endmodule

// ### tb/sfp_link_tb.sv
/*
 * Self-checking bench for the serial flash pin link.
 * Assumes sfp_master drives the pins; protect checks are driven here.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; \
	if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module sfp_link_tb;
	logic clock_i = 1'b0; // 50 MHz
	logic rst_b_i = 1'b0; // Reset, active low
	logic busy_i = 1'b0; // Array busy
	logic wp_b_i = 1'b1; // Write protect pin
	logic prog_req_i = 1'b0; // Check request
	logic [2:0] bp_i = 3'h0; // Protect code
	logic [19:0] adr_i = 20'h00000; // Checked address
	logic [7:0] tx_byte_i = 8'h00; // Device next byte
	logic [7:0] tx_nx = 8'h00; // Byte fed on tx_req
	logic [7:0] rx; // Master received byte
	logic [7:0] rx_byte;
	logic cs_b, sck, si, hold_b, so, so_oe, tx_req, rx_v, fs, act, pau, stby, ack, ok;
	int err_count = 0;
	int cmp_count = 0;
	int nv = 0;
	int nf = 0;
	int np = 0;
	always #10 clock_i = ~clock_i;
	// Pulse counters and the next-byte feed
	always @(posedge clock_i) begin
		if (tx_req) tx_byte_i <= tx_nx;
		if (rx_v) nv <= nv + 1;
		if (fs) nf <= nf + 1;
		if (pau && act && !so_oe) np <= np + 1;
	end
	sfp_master m (.clock_i(clock_i), .so_i(so), .so_oe_i(so_oe), .cs_b_o(cs_b),
		.sck_o(sck), .si_o(si), .hold_b_o(hold_b));
	sfp_link dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sck_i(sck),
		.si_i(si), .hold_b_i(hold_b), .wp_b_i(wp_b_i), .so_o(so), .so_oe_o(so_oe),
		.tx_byte_i(tx_byte_i), .tx_req_o(tx_req), .rx_byte_o(rx_byte), .rx_valid_o(rx_v),
		.frame_start_o(fs), .active_o(act), .paused_o(pau), .busy_i(busy_i),
		.standby_o(stby), .block_protect_bits_i(bp_i), .prog_req_i(prog_req_i),
		.prog_addr_i(adr_i), .prog_ack_o(ack), .prog_ok_o(ok));
	task automatic wt(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Allowed writes per protect code; a high protect pin allows all
	function automatic logic ok_exp(input logic wp, input logic [2:0] c, input logic [19:0] a);
		case (c)
			3'h0: ok_exp = 1'b1;
			3'h1: ok_exp = a < 20'hf0000;
			3'h2: ok_exp = a < 20'he0000;
			3'h3: ok_exp = a < 20'hc0000;
			3'h4: ok_exp = a < 20'h80000;
			default: ok_exp = 1'b0;
		endcase
		ok_exp = ok_exp | wp;
	endfunction
	// Traffic with select low since reset must be ignored
	task automatic t_unarmed();
		m.bits(8'hff, 8, -1, rx);
		wt(4);
		`CHK("rx_valid", 0, nv)
		`CHK("so_oe", 1'b0, so_oe)
		`CHK("active", 1'b0, act)
		m.desel();
	endtask
	// Two bytes each way, then deselect
	task automatic t_frame(input logic m3, input logic [7:0] b0, b1, t0, t1);
		@(posedge clock_i);
		tx_byte_i <= t0;
		tx_nx <= t1;
		nv = 0;
		nf = 0;
		m.sel(m3);
		`CHK("frame", 1, nf)
		`CHK("active", 1'b1, act)
		`CHK("standby", 1'b0, stby)
		`CHK("so_oe", 1'b1, so_oe)
		m.bits(b0, 8, -1, rx);
		wt(4);
		`CHK("so byte0", t0, rx)
		`CHK("rx byte0", b0, rx_byte)
		m.bits(b1, 8, -1, rx);
		wt(4);
		`CHK("so byte1", t1, rx)
		`CHK("rx byte1", b1, rx_byte)
		`CHK("rx_valid", 2, nv)
		m.desel();
		`CHK("so_oe", 1'b0, so_oe)
		`CHK("active", 1'b0, act)
		`CHK("standby", 1'b1, stby)
	endtask
	// Partial byte dropped; count restarts at the next select
	task automatic t_partial();
		m.sel(1'b0);
		m.bits(8'hff, 3, -1, rx);
		m.desel();
		@(posedge clock_i);
		tx_byte_i <= 8'h55;
		m.sel(1'b0);
		m.bits(8'h7e, 8, -1, rx);
		wt(4);
		`CHK("rx partial", 8'h7e, rx_byte)
		`CHK("so partial", 8'h55, rx)
		m.desel();
	endtask
	// Pause mid-byte with junk edges; the byte resumes intact
	task automatic t_hold();
		@(posedge clock_i);
		tx_byte_i <= 8'hd2;
		np = 0;
		m.sel(1'b0);
		m.bits(8'h4b, 8, 4, rx);
		wt(4);
		`CHK("paused seen", 1'b1, np > 0)
		`CHK("rx hold", 8'h4b, rx_byte)
		`CHK("so hold", 8'hd2, rx)
		`CHK("paused", 1'b0, pau)
		`CHK("active", 1'b1, act)
		m.desel();
	endtask
	// Deselected but busy is not standby
	task automatic t_busy();
		@(posedge clock_i);
		busy_i <= 1'b1;
		wt(4);
		`CHK("standby busy", 1'b0, stby)
		busy_i <= 1'b0;
		wt(4);
		`CHK("standby idle", 1'b1, stby)
	endtask
	// Every code, both pin levels, region edges
	task automatic t_protect();
		logic [19:0] av[9] = '{20'h7ffff, 20'h80000, 20'hbffff, 20'hc0000, 20'hdffff,
			20'he0000, 20'heffff, 20'hf0000, 20'hfffff};
		for (int w = 0; w < 2; w++) begin
			@(posedge clock_i);
			wp_b_i <= w[0];
			wt(4);
			for (int c = 0; c < 8; c++) begin
				for (int k = 0; k < 9; k++) begin
					@(posedge clock_i);
					bp_i <= c[2:0];
					adr_i <= av[k];
					prog_req_i <= 1'b1;
					@(posedge clock_i);
					prog_req_i <= 1'b0;
					#1;
					`CHK("prog_ack", 1'b1, ack)
					`CHK("prog_ok", ok_exp(w[0], c[2:0], av[k]), ok)
				end
			end
		end
	endtask
	initial begin
		wt(8);
		`CHK("so_oe reset", 1'b0, so_oe)
		rst_b_i <= 1'b1;
		wt(4);
		`CHK("standby reset", 1'b1, stby)
		t_unarmed();
		t_frame(1'b0, 8'ha5, 8'h81, 8'h3c, 8'h5a);
		t_partial();
		t_hold();
		t_busy();
		t_protect();
		t_frame(1'b1, 8'hc3, 8'h18, 8'h96, 8'he7);
		report_and_stop();
	end
	// Generous span over the roughly one thousand cycles the tests need
	initial begin
		#1000000;
		err_count++;
		report_and_stop();
	end
endmodule
